// [dual_switch_spi_control.sv]
// Top of the dual high-side switch control logic.
// Assumes pins are asynchronous; analog parts sit outside.
module dual_switch_spi_control
  import sw_pkg::*;
#(
  parameter int WD_TICK = WD_TICK_CYC,
  parameter int OCH_WIN = OCH_CYC
) (
  input wire logic i_clk,
  input wire logic i_sys_rst,
  input wire logic i_cs_n,
  input wire logic i_sclk,
  input wire logic i_si,
  input wire logic i_reset_n,
  input wire logic i_wake,
  input wire logic i_logic_supply_ok,
  input wire logic [1:0] i_failsafe_select_input,
  input wire logic [1:0] i_direct_input,
  input wire logic [1:0] i_fault,
  input wire logic [1:0] i_overcurrent_high,
  input wire logic [1:0] i_overcurrent_low,
  output logic o_so,
  output logic o_so_oe_n,
  output logic o_high_side_output_a,
  output logic o_high_side_output_b,
  output logic o_current_sense_select,
  output logic o_current_sense_output_oe_n,
  output logic o_fault_flag_n_out,
  output logic o_fault_flag_n_oe_n,
  output logic [1:0] o_mode
);
  spi_if link ();
  // Synchronisers for the slow control pins.
  // Seven pin bits: reset, wake, supply good, selector, direct inputs.
  logic [6:0] p1, p2;
  logic rst_n, wake, supply_ok, rst_d;
  logic [1:0] fsel, din;
  // Configuration registers.
  logic [1:0] out_on; // Serial on/off per output.
  logic [1:0] direct_en; // Direct input enable per output.
  logic sense_ch, sense_off; // Sense channel and tri-state.
  logic [1:0] wd_sel; // Watchdog timeout select.
  logic low_oc_en; // Use programmed low threshold after blanking.
  // Latched faults.
  logic [1:0] fault;
  // Watchdog state.
  mode_t mode;
  logic wd_run, wd_last;
  logic [31:0] tick_cnt;
  logic [11:0] ms_cnt, wd_limit;
  // Blanking timers after each turn-on.
  logic [31:0] blank_cnt [2];
  logic [1:0] on_q, on_d;
  logic cfg_clr, wd_on, cmd_ok;
  logic [2:0] addr;
  logic [3:0] data;

  spi_rx u_rx (
    .i_clk(i_clk),
    .i_sys_rst(i_sys_rst),
    .i_cs_n(i_cs_n),
    .i_sclk(i_sclk),
    .i_si(i_si),
    .o_so(o_so),
    .o_so_oe_n(o_so_oe_n),
    .bus(link)
  );

  // Control pins pass two flip-flops before use.
  always_ff @(posedge i_clk) begin
    if (i_sys_rst) begin
      p1 <= 7'h00;
      p2 <= 7'h00;
    end else begin
      p1 <= {i_reset_n, i_wake, i_logic_supply_ok,
             i_failsafe_select_input, i_direct_input};
      p2 <= p1;
    end
  end
  assign rst_n = p2[6];
  assign wake = p2[5];
  assign supply_ok = p2[4];
  assign fsel = p2[3:2];
  assign din = p2[1:0];
  assign addr = link.cmd[ADDR_MSB:ADDR_LSB];
  assign data = link.cmd[3:0];
  assign cmd_ok = link.cmd_valid && rst_n;
  assign cfg_clr = ~rst_n | ~supply_ok;
  assign wd_on = (wake | rst_n) && (fsel != FS_DISABLED);

  // Configuration written by commands.
  always_ff @(posedge i_clk) begin
    if (i_sys_rst || cfg_clr) begin
      out_on <= 2'h0;
      direct_en <= 2'h0;
      sense_ch <= 1'b0;
      sense_off <= 1'b1;
      wd_sel <= 2'h0;
      low_oc_en <= 1'b0;
    end else if (mode == MODE_FAILSAFE) begin
      // Overcurrent settings fall back to default in fail-safe.
      low_oc_en <= 1'b0;
    end else if (cmd_ok) begin
      unique case (addr)
        ADDR_OUT_CTRL: out_on <= data[1:0];
        ADDR_SENSE: begin
          sense_ch <= data[0];
          sense_off <= data[1];
        end
        ADDR_DIRECT: direct_en <= data[1:0];
        ADDR_BLANK: low_oc_en <= data[0];
        ADDR_WDOG: wd_sel <= data[1:0];
        default: ;
      endcase
    end
  end

  // Reset edge history.
  always_ff @(posedge i_clk) begin
    if (i_sys_rst) begin
      rst_d <= 1'b0;
    end else begin
      rst_d <= rst_n;
    end
  end

  // Timeout limit from the selected setting.
  always_comb begin
    unique case (wd_sel)
      2'h0: wd_limit = 12'(WDTO0_MS);
      2'h1: wd_limit = 12'(WDTO1_MS);
      2'h2: wd_limit = 12'(WDTO2_MS);
      default: wd_limit = 12'(WDTO3_MS);
    endcase
  end

  // Watchdog and mode; the millisecond divider makes long waits cheap.
  always_ff @(posedge i_clk) begin
    if (i_sys_rst) begin
      mode <= MODE_SLEEP;
      wd_run <= 1'b0;
      wd_last <= 1'b0;
      tick_cnt <= 32'h0;
      ms_cnt <= 12'h0;
    end else if (!wake && !rst_n) begin
      mode <= MODE_SLEEP;
      wd_run <= 1'b0;
    end else if (!wd_on) begin
      if (mode == MODE_SLEEP || fsel == FS_DISABLED) begin
        mode <= MODE_NORMAL;
      end
      wd_run <= 1'b0;
    end else begin
      if (mode == MODE_SLEEP) begin
        mode <= MODE_NORMAL;
      end
      if ((rst_n && !rst_d) || mode == MODE_SLEEP) begin
        wd_run <= 1'b1;
        tick_cnt <= 32'h0;
        ms_cnt <= 12'h0;
      end else if (cmd_ok && link.cmd[WD_BIT_POS] != wd_last) begin
        wd_last <= link.cmd[WD_BIT_POS];
        tick_cnt <= 32'h0;
        ms_cnt <= 12'h0;
      end else if (wd_run && mode == MODE_NORMAL) begin
        if (tick_cnt == 32'(WD_TICK - 1)) begin
          tick_cnt <= 32'h0;
          ms_cnt <= ms_cnt + 12'h1;
        end else begin
          tick_cnt <= tick_cnt + 32'h1;
        end
        if (ms_cnt >= wd_limit) begin
          mode <= MODE_FAILSAFE;
        end
      end
    end
  end

  always_comb begin
    on_d = o_high_side_output_a ? 2'h1 : 2'h0;
    on_d[1] = o_high_side_output_b;
  end
  for (genvar g = 0; g < 2; g++) begin : g_ch
    always_ff @(posedge i_clk) begin
      if (i_sys_rst || (on_d[g] && !on_q[g])) begin
        blank_cnt[g] <= 32'h0;
      end else if (blank_cnt[g] != 32'(OCH_WIN)) begin
        blank_cnt[g] <= blank_cnt[g] + 32'h1;
      end
    end
    // Faults: severe level any time, low level only past blanking.
    always_ff @(posedge i_clk) begin
      if (i_sys_rst || cfg_clr) begin
        fault[g] <= 1'b0;
      end else if (i_fault[g] || i_overcurrent_high[g] ||
                   (low_oc_en && i_overcurrent_low[g] &&
                    blank_cnt[g] == 32'(OCH_WIN))) begin
        fault[g] <= 1'b1;
      end
    end
  end
  always_ff @(posedge i_clk) begin
    if (i_sys_rst) begin
      on_q <= 2'h0;
    end else begin
      on_q <= on_d;
    end
  end

  // Output drive, registered.
  always_ff @(posedge i_clk) begin
    if (i_sys_rst || mode == MODE_SLEEP) begin
      o_high_side_output_a <= 1'b0;
      o_high_side_output_b <= 1'b0;
    end else if (mode == MODE_FAILSAFE) begin
      o_high_side_output_a <= (fsel == FS_BOTH_ON) || (fsel == FS_A_ONLY);
      o_high_side_output_b <= (fsel == FS_BOTH_ON);
    end else begin
      o_high_side_output_a <= ~fault[0] &
        (direct_en[0] ? din[0] : out_on[0]);
      o_high_side_output_b <= ~fault[1] &
        (direct_en[1] ? din[1] : out_on[1]);
    end
  end

  // Sense and fault flag drive, registered.
  always_ff @(posedge i_clk) begin
    if (i_sys_rst) begin
      o_current_sense_select <= 1'b0;
      o_current_sense_output_oe_n <= 1'b1;
      o_fault_flag_n_oe_n <= 1'b1;
    end else begin
      o_current_sense_select <= sense_ch;
      o_current_sense_output_oe_n <= sense_off | (mode == MODE_SLEEP);
      o_fault_flag_n_oe_n <= ~(|fault);
    end
  end
  assign o_fault_flag_n_out = 1'b0;
  assign o_mode = mode;
  // Status byte: mode, selector, faults.
  assign link.status = {2'(mode), fsel, 2'h0, fault};
endmodule

// [dual_switch_spi_control_sva.sv]
// Checker for the switch control block, bound to its top-level ports.
// Assumes one clock domain with a synchronous active-high reset.
module dual_switch_spi_control_sva
  import sw_pkg::*;
#(
  parameter int WD_TICK = 10,
  parameter int OCH_WIN = 8
) (
  input logic i_clk,
  input logic i_sys_rst,
  input logic i_cs_n,
  input logic i_reset_n,
  input logic i_wake,
  input logic i_logic_supply_ok,
  input logic [1:0] i_failsafe_select_input,
  input logic [1:0] i_fault,
  input logic o_so_oe_n,
  input logic o_high_side_output_a,
  input logic o_high_side_output_b,
  input logic o_current_sense_select,
  input logic o_current_sense_output_oe_n,
  input logic o_fault_flag_n_oe_n,
  input logic [1:0] o_mode
);
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (i_sys_rst);
  // The margins cover the two-stage pin synchronisers.
  sequence link_idle;
    (i_cs_n && i_reset_n && i_logic_supply_ok) [*8];
  endsequence
  sequence asleep;
    (!i_wake && !i_reset_n) [*5];
  endsequence
  sequence fs_held(logic [1:0] c);
    (o_mode == MODE_FAILSAFE && i_failsafe_select_input == c) [*5];
  endsequence
  a_so_release: assert property (i_cs_n [*5] |-> o_so_oe_n)
    else $error("serial out driven while deselected");
  a_so_drive: assert property ((!i_cs_n) [*5] |-> !o_so_oe_n)
    else $error("serial out idle while selected");
  a_idle_hold: assert property (link_idle |=>
    $stable(o_current_sense_select) && $stable(o_current_sense_output_oe_n))
    else $error("configuration changed while deselected");
  a_sleep_off: assert property (asleep |-> o_mode == MODE_SLEEP &&
    !o_high_side_output_a && !o_high_side_output_b)
    else $error("outputs on in sleep");
  a_reset_clears: assert property ((!i_reset_n && i_fault == 2'h0) [*5]
    |-> o_fault_flag_n_oe_n && o_current_sense_output_oe_n)
    else $error("reset pin did not clear registers");
  a_fault_pulls: assert property (
    (i_fault != 2'h0 && i_reset_n && i_logic_supply_ok) [*4]
    |-> !o_fault_flag_n_oe_n)
    else $error("fault flag not pulled low");
  a_fs_disabled: assert property (
    (i_failsafe_select_input == FS_DISABLED) [*4] |-> o_mode != MODE_FAILSAFE)
    else $error("fail-safe entered with selector grounded");
  a_fs_both_off: assert property (fs_held(FS_BOTH_OFF) |->
    !o_high_side_output_a && !o_high_side_output_b)
    else $error("fail-safe outputs not both off");
  a_fs_a_only: assert property (fs_held(FS_A_ONLY) |->
    o_high_side_output_a && !o_high_side_output_b)
    else $error("fail-safe outputs not first only");
  a_fs_both_on: assert property (fs_held(FS_BOTH_ON) |->
    o_high_side_output_a && o_high_side_output_b)
    else $error("fail-safe outputs not both on");
  a_supply_loss: assert property (
    (!i_logic_supply_ok) [*5] |-> o_current_sense_output_oe_n)
    else $error("configuration kept after supply loss");
endmodule

bind dual_switch_spi_control dual_switch_spi_control_sva #(
  .WD_TICK(WD_TICK), .OCH_WIN(OCH_WIN)) u_sva (.i_clk, .i_sys_rst, .i_cs_n,
  .i_reset_n, .i_wake, .i_logic_supply_ok, .i_failsafe_select_input,
  .i_fault, .o_so_oe_n, .o_high_side_output_a, .o_high_side_output_b,
  .o_current_sense_select, .o_current_sense_output_oe_n,
  .o_fault_flag_n_oe_n, .o_mode);

// [host_master_model.sv]
// Host model: the serial master that drives the link of the block.
// Assumes the bench calls one task at a time; bit period is 160 ns.
module host_master_model (
  output logic o_cs_n,
  output logic o_sclk,
  output logic o_si,
  input wire logic i_so
);
  timeunit 1ns;
  timeprecision 1ps;
  logic wd_tog = 1'h0; // Watchdog toggle bit of the next word.
  // Idle levels follow the pin pulls: select high, clock and data low.
  initial begin
    o_cs_n = 1'h1;
    o_sclk = 1'h0;
    o_si = 1'h0;
  end
  // select, MSB first, toggled top bit.
  task automatic send(input logic [6:0] body, input int nbits,
                      output logic [7:0] rx);
    logic [7:0] w;
    w = {wd_tog, body};
    // A dropped short word must not count as a toggle.
    if (nbits == 8) begin
      wd_tog = ~wd_tog;
    end
    rx = 8'h00;
    #3;
    o_cs_n = 1'h0;
    for (int i = 7; i > 7 - nbits; i--) begin
      o_si = w[i];
      #80;
      rx = {rx[6:0], i_so};
      o_sclk = 1'h1;
      #80;
      o_sclk = 1'h0;
    end
    #80;
    o_cs_n = 1'h1;
    o_si = 1'h0;
    #320;
  endtask
  // traffic for another device while this select stays high.
  task automatic stray();
    for (int i = 0; i < 8; i++) begin
      o_si = ~o_si;
      #80 o_sclk = 1'h1;
      #80 o_sclk = 1'h0;
    end
    o_si = 1'h0;
  endtask
endmodule

// [spi_if.sv]
// Interface carrying received commands from the serial receiver.
// Assumes both ends run on the same system clock.
interface spi_if;
  logic cmd_valid; // One-cycle pulse at chip-select release.
  logic [7:0] cmd; // Last complete command word.
  logic [7:0] status; // Status byte shifted out.
  modport rx (output cmd_valid, output cmd, input status);
  modport core (input cmd_valid, input cmd, output status);
endinterface

// [spi_rx.sv]
// Serial receiver: samples the link pins and shifts commands in.
// Assumes raw asynchronous pins; synchronises them itself.
module spi_rx
  import sw_pkg::*;
(
  input wire logic i_clk,
  input wire logic i_sys_rst,
  input wire logic i_cs_n,
  input wire logic i_sclk,
  input wire logic i_si,
  output logic o_so,
  output logic o_so_oe_n,
  spi_if.rx bus
);
  // Two-stage synchronisers; stage one feeds only stage two.
  logic [2:0] s1, s2;
  // Previous sampled clock and chip select for edge detection.
  logic sclk_d, cs_d;
  // Shift register and bit count.
  logic [7:0] shreg;
  logic [3:0] nbits;
  // Output shift register.
  logic [7:0] oreg;
  logic cs_n, sclk, si, rise, cs_up, cs_down;

  // Synchronise all three pins.
  always_ff @(posedge i_clk) begin
    if (i_sys_rst) begin
      // Idle pin levels: select high, clock and data low, so no false edge.
      s1 <= 3'h4;
      s2 <= 3'h4;
    end else begin
      s1 <= {i_cs_n, i_sclk, i_si};
      s2 <= s1;
    end
  end
  assign cs_n = s2[2];
  assign sclk = s2[1];
  assign si = s2[0];

  // Edge history.
  always_ff @(posedge i_clk) begin
    if (i_sys_rst) begin
      sclk_d <= 1'b0;
      cs_d <= 1'b1;
    end else begin
      sclk_d <= sclk;
      cs_d <= cs_n;
    end
  end
  assign rise = sclk & ~sclk_d & ~cs_n;
  assign cs_up = cs_n & ~cs_d;
  assign cs_down = ~cs_n & cs_d;

  always_ff @(posedge i_clk) begin
    if (i_sys_rst || cs_down) begin
      shreg <= 8'h00;
      nbits <= 4'h0;
    end else if (rise) begin
      shreg <= {shreg[6:0], si};
      if (nbits != 4'hF) begin
        nbits <= nbits + 4'h1;
      end
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_sys_rst) begin
      bus.cmd_valid <= 1'b0;
      bus.cmd <= 8'h00;
    end else begin
      bus.cmd_valid <= cs_up && (nbits == 4'(CMD_BITS));
      if (cs_up && (nbits == 4'(CMD_BITS))) begin
        bus.cmd <= shreg;
      end
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_sys_rst) begin
      oreg <= 8'h00;
      o_so <= 1'b0;
      o_so_oe_n <= 1'b1;
    end else begin
      o_so_oe_n <= cs_n;
      if (cs_down) begin
        oreg <= {bus.status[6:0], 1'b0};
        o_so <= bus.status[7];
      end else if (rise) begin
        oreg <= {oreg[6:0], 1'b0};
        o_so <= oreg[7];
      end
    end
  end
endmodule

// [sw_pkg.sv]
// Package for the dual high-side switch serial control block.
// Assumes a 100 MHz system clock; all link pins arrive asynchronously.
package sw_pkg;
  // Command word width in bits.
  localparam int CMD_BITS = 8;
  // Position of the watchdog toggle bit in a command.
  localparam int WD_BIT_POS = 7;
  // Command field positions: bits 6:4 select the target, 3:0 carry data.
  localparam int ADDR_MSB = 6;
  localparam int ADDR_LSB = 4;
  // Command targets.
  localparam logic [2:0] ADDR_OUT_CTRL = 3'h1;
  localparam logic [2:0] ADDR_SENSE = 3'h2;
  localparam logic [2:0] ADDR_DIRECT = 3'h3;
  localparam logic [2:0] ADDR_BLANK = 3'h4;
  localparam logic [2:0] ADDR_WDOG = 3'h5;
  // Reset values of configuration.
  localparam logic [3:0] CFG_RESET = 4'h0;
  // Fail-safe selector codes.
  localparam logic [1:0] FS_DISABLED = 2'h0;
  localparam logic [1:0] FS_BOTH_OFF = 2'h1;
  localparam logic [1:0] FS_A_ONLY = 2'h2;
  localparam logic [1:0] FS_BOTH_ON = 2'h3;
  // System clock period in ns.
  localparam int CLK_NS = 10;
  // Watchdog tick period in microseconds and its cycle count.
  localparam int WD_TICK_US = 1000;
  localparam int WD_TICK_CYC = WD_TICK_US * 1000 / CLK_NS;
  // Watchdog timeouts in ms, selected by two configuration bits.
  localparam int WDTO0_MS = 620;
  localparam int WDTO1_MS = 310;
  localparam int WDTO2_MS = 2500;
  localparam int WDTO3_MS = 1250;
  // High-level blanking window in microseconds and its cycle count.
  localparam int OCH_US = 10;
  localparam int OCH_CYC = OCH_US * 1000 / CLK_NS;
  // Operating modes, Gray coded along sleep, normal, fail-safe.
  typedef enum logic [1:0] {
    MODE_SLEEP = 2'b00,
    MODE_NORMAL = 2'b01,
    MODE_FAILSAFE = 2'b11
  } mode_t;
endpackage

// [tb.sv]
// Self-checking bench: the host model sends commands, checks follow.
// Assumes a 100 MHz clock and a watchdog tick shortened to 10 cycles.
module tb;
  import sw_pkg::*;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk, rst, cs_n, sclk, si, so, so_oe_n, rst_pin_n, wake, sup_ok;
  logic a, b, sns_sel, sns_oe_n, flag, flag_oe_n;
  logic [1:0] fsel, din, flt, mode;
  logic [1:0] och, ocl; // Overcurrent comparator levels per output.
  logic [7:0] st; // Status byte read back from the block.
  int errors = 0; // Mismatches seen.
  int n_tests = 0; // Comparisons made.
  // The clock inverts every 5 ns.
  initial begin
    clk = 1'h0;
    forever #5 clk = ~clk;
  end
  // A released serial output shows the inverse of its last level.
  host_master_model host (.o_cs_n(cs_n), .o_sclk(sclk), .o_si(si),
    .i_so(so_oe_n ? ~so : so));
  dual_switch_spi_control #(.WD_TICK(10), .OCH_WIN(200)) dut (
    .i_clk(clk), .i_sys_rst(rst), .i_cs_n(cs_n), .i_sclk(sclk), .i_si(si),
    .i_reset_n(rst_pin_n), .i_wake(wake), .i_logic_supply_ok(sup_ok),
    .i_failsafe_select_input(fsel), .i_direct_input(din), .i_fault(flt),
    .i_overcurrent_high(och), .i_overcurrent_low(ocl), .o_so(so),
    .o_so_oe_n(so_oe_n), .o_high_side_output_a(a),
    .o_high_side_output_b(b), .o_current_sense_select(sns_sel),
    .o_current_sense_output_oe_n(sns_oe_n), .o_fault_flag_n_out(flag),
    .o_fault_flag_n_oe_n(flag_oe_n), .o_mode(mode));
  task automatic test_done();
    $display("errors %0d, comparisons %0d", errors, n_tests);
    if (errors == 0 && n_tests > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask
  task automatic chk(input string nm, input logic [7:0] e,
                     input logic [7:0] g);
    n_tests++;
    if (g !== e) begin
      errors++;
      $display("wrong value %s exp %h got %h", nm, e, g);
    end
  endtask
  task automatic outs(input logic ea, input logic eb);
    chk("out_a", 8'(ea), 8'(a));
    chk("out_b", 8'(eb), 8'(b));
  endtask
  // Waits n edges, then steps off the edge before driving.
  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  task automatic cmd(input logic [6:0] w);
    host.send(w, 8, st);
    cyc(1);
  endtask
  // The tests need about 15300 cycles; allow over twice as many.
  initial begin
    #350000;
    errors++;
    test_done();
  end
  initial begin
    rst = 1'h1;
    rst_pin_n = 1'h0;
    wake = 1'h0;
    sup_ok = 1'h1;
    fsel = FS_BOTH_ON;
    din = 2'h0;
    flt = 2'h0;
    och = 2'h0;
    ocl = 2'h0;
    cyc(16);
    rst = 1'h0;
    cyc(8);
    chk("mode", 8'(MODE_SLEEP), 8'(mode));
    rst_pin_n = 1'h1;
    wake = 1'h1;
    cyc(8);
    chk("mode", 8'(MODE_NORMAL), 8'(mode));
    chk("sense_oe_n", 8'h01, 8'(sns_oe_n));
    cmd(7'h13);
    outs(1'h1, 1'h1);
    cmd(7'h12);
    outs(1'h0, 1'h1);
    host.send(7'h11, 7, st);
    cyc(1);
    outs(1'h0, 1'h1);
    host.stray();
    cyc(8);
    outs(1'h0, 1'h1);
    cmd(7'h11);
    chk("status", {MODE_NORMAL, FS_BOTH_ON, 4'h0}, {st[7:4], 4'h0});
    cmd(7'h21);
    chk("sense_sel", 8'h01, 8'(sns_sel));
    chk("sense_oe_n", 8'h00, 8'(sns_oe_n));
    // The second output turns on fresh, so its blanking window starts.
    cmd(7'h41);
    cmd(7'h13);
    ocl = 2'h2;
    cyc(8);
    outs(1'h1, 1'h1);
    och = 2'h1;
    cyc(8);
    outs(1'h0, 1'h1);
    chk("flag_oe_n", 8'h00, 8'(flag_oe_n));
    och = 2'h0;
    cyc(200);
    outs(1'h0, 1'h0);
    ocl = 2'h0;
    sup_ok = 1'h0;
    cyc(8);
    chk("sense_oe_n", 8'h01, 8'(sns_oe_n));
    outs(1'h0, 1'h0);
    sup_ok = 1'h1;
    cmd(7'h33);
    din = 2'h1;
    cyc(6);
    outs(1'h1, 1'h0);
    din = 2'h2;
    cyc(6);
    outs(1'h0, 1'h1);
    cmd(7'h30);
    outs(1'h0, 1'h0);
    din = 2'h0;
    cmd(7'h51);
    cyc(2700);
    chk("mode", 8'(MODE_NORMAL), 8'(mode));
    cyc(600);
    chk("mode", 8'(MODE_FAILSAFE), 8'(mode));
    // Each enabled selector code in turn sets its own output pair.
    for (int k = 3; k > 0; k--) begin
      fsel = 2'(k);
      cyc(8);
      outs(k > 1, k == 3);
    end
    fsel = FS_DISABLED;
    cyc(3500);
    chk("mode", 8'(MODE_NORMAL), 8'(mode));
    flt = 2'h2;
    cyc(8);
    chk("flag_oe_n", 8'h00, 8'(flag_oe_n));
    chk("flag", 8'h00, 8'(flag));
    flt = 2'h0;
    rst_pin_n = 1'h0;
    wake = 1'h0;
    din = 2'h3;
    cyc(8);
    chk("mode", 8'(MODE_SLEEP), 8'(mode));
    outs(1'h0, 1'h0);
    chk("flag_oe_n", 8'h01, 8'(flag_oe_n));
    din = 2'h0;
    fsel = FS_A_ONLY;
    rst_pin_n = 1'h1;
    cyc(6000);
    chk("mode", 8'(MODE_NORMAL), 8'(mode));
    cyc(400);
    chk("mode", 8'(MODE_FAILSAFE), 8'(mode));
    outs(1'h1, 1'h0);
    test_done();
  end
endmodule
